// *** include/clgb_defs.svh ***
// timing and field constants for the logic gate blocks
`ifndef CLGB_DEFS_SVH
`define CLGB_DEFS_SVH
`define CLGB_CLK_NS 25
`define CLGB_SCAN_NS 1000
`define CLGB_STEP_NS 10000000
`define CLGB_SCAN_CYC ((`CLGB_SCAN_NS + `CLGB_CLK_NS - 1) / `CLGB_CLK_NS)
`define CLGB_TB_SEC 2'h0
`define CLGB_TB_MIN 2'h1
`define CLGB_TB_HR 2'h2
`define CLGB_TB_10MS 2'h3
`define CLGB_HUND_PER_SEC 16'h0064
`define CLGB_SEC_PER_MIN 16'h003c
`define CLGB_MIN_PER_HR 16'h003c
`endif

// *** include/clgb_pkg.sv ***
// types for the logic gate blocks
package clgb_pkg;
   typedef enum logic [1:0] {
      CLGB_TB_SEC_E,
      CLGB_TB_MIN_E,
      CLGB_TB_HR_E,
      CLGB_TB_10MS_E
   } clgb_timebase_t;
   typedef enum {
      CLGB_SW_IDLE,
      CLGB_SW_RUN,
      CLGB_SW_LAP
   } clgb_sw_state_t;
endpackage

// *** hdl/clgb_gate4.sv ***
// four-input gate evaluation with input inversion and unused defaults
`timescale 1ns/1ps
module clgb_gate4 (
   input wire logic [3:0] in_val,
   input wire logic [3:0] in_used,
   input wire logic [3:0] in_inv,
   input wire logic unused_one,
   output logic all_one,
   output logic any_one
);
   logic [3:0] eff;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (in_used[i]) begin
            eff[i] = in_val[i] ^ in_inv[i];
         end else begin
            eff[i] = unused_one;
         end
      end
      all_one = &eff;
      any_one = |eff;
   end
endmodule

// *** hdl/clgb_time.sv ***
// time parameter to hundredths of a second conversion
`timescale 1ns/1ps
`include "clgb_defs.svh"
module clgb_time (
   input wire logic [1:0] timebase,
   input wire logic [15:0] major,
   input wire logic [15:0] minor,
   output logic [31:0] hundredths
);
   logic [31:0] secs;
   always_comb begin
      secs = 32'h0;
      hundredths = 32'h0;
      case (timebase)
         `CLGB_TB_SEC: begin
            hundredths = {16'h0, major} * {16'h0, `CLGB_HUND_PER_SEC}
               + {16'h0, minor};
         end
         `CLGB_TB_MIN: begin
            secs = {16'h0, major} * {16'h0, `CLGB_SEC_PER_MIN}
               + {16'h0, minor};
            hundredths = 32'(secs * {16'h0, `CLGB_HUND_PER_SEC});
         end
         `CLGB_TB_HR: begin
            secs = ({16'h0, major} * {16'h0, `CLGB_MIN_PER_HR}
               + {16'h0, minor}) * {16'h0, `CLGB_SEC_PER_MIN};
            hundredths = 32'(secs * {16'h0, `CLGB_HUND_PER_SEC});
         end
         default: begin
            hundredths = {16'h0, minor}; // 10 ms steps
         end
      endcase
   end
endmodule

// *** hdl/clgb_blocks.sv ***
// scan-cycle gate library with special-function input conventions
// What this block does
// - Each basic gate input can be inverted individually.
// - AND outputs 1 only when all inputs are 1.
// - Edge AND: 1 when all inputs 1 now, some input 0 before.
// - Unused inputs of AND and NAND kinds read as 1.
// - NAND outputs 0 only when all inputs are 1.
// - Edge NAND: 1 when some input 0 now, all inputs 1 before.
// - OR outputs 1 when any input is 1.
// - Unused inputs of OR, NOR, XOR read as 0.
// - NOR outputs 1 only when all inputs are 0.
// - XOR of two inputs is 1 when they differ.
// - NOT outputs the complement of its input.
// - Set input drives the special block output to 1.
// - Reset input overrides everything and clears outputs.
// - Enable low makes the special block ignore other inputs except reset and reset-all.
// - Invert input inverts the special block output.
// - Reset-all clears all internal values of the block.
// - Lap input pauses the stopwatch.
// - Unused special block logic inputs read as 0.
// - Time parameter read as s:1/100, m:s or h:m per timebase.
// - Stopwatch also offers a 10 ms timebase.
`timescale 1ns/1ps
`include "clgb_defs.svh"
module clgb_blocks (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [3:0] AND_IN,
   input wire logic [3:0] AND_USED,
   input wire logic [3:0] AND_INV,
   input wire logic [3:0] NAND_IN,
   input wire logic [3:0] NAND_USED,
   input wire logic [3:0] NAND_INV,
   input wire logic [3:0] OR_IN,
   input wire logic [3:0] OR_USED,
   input wire logic [3:0] OR_INV,
   input wire logic [3:0] NOR_IN,
   input wire logic [3:0] NOR_USED,
   input wire logic [3:0] NOR_INV,
   input wire logic [1:0] XOR_IN,
   input wire logic [1:0] XOR_USED,
   input wire logic [1:0] XOR_INV,
   input wire logic NOT_IN,
   input wire logic NOT_INV,
   input wire logic SFB_SET,
   input wire logic SFB_SET_USED,
   input wire logic SFB_RST,
   input wire logic SFB_RST_USED,
   input wire logic SFB_EN,
   input wire logic SFB_EN_USED,
   input wire logic SFB_INVOUT,
   input wire logic SFB_INVOUT_USED,
   input wire logic SFB_RALL,
   input wire logic SFB_RALL_USED,
   input wire logic SFB_LAP,
   input wire logic SFB_LAP_USED,
   input wire logic SFB_START,
   input wire logic SFB_START_USED,
   input wire logic [1:0] SW_TIMEBASE,
   input wire logic [15:0] PAR_MAJOR,
   input wire logic [15:0] PAR_MINOR,
   output logic SCAN_TICK,
   output logic AND_Q,
   output logic AND_EDGE_Q,
   output logic NAND_Q,
   output logic NAND_EDGE_Q,
   output logic OR_Q,
   output logic NOR_Q,
   output logic XOR_Q,
   output logic NOT_Q,
   output logic SFB_Q,
   output logic [31:0] SW_ELAPSED,
   output logic [31:0] PAR_HUNDREDTHS,
   output logic SW_RUNNING,
   output logic SW_PAUSED
);
   localparam int SCAN_CYC = `CLGB_SCAN_CYC;
   localparam int TICK10_CYC =
      (`CLGB_STEP_NS + `CLGB_CLK_NS - 1) / `CLGB_CLK_NS;

   logic [15:0] scan_cnt;
   logic scan;
   logic [31:0] tick_cnt;
   logic tick10;
   logic and_all, nand_all;
   logic or_any, nor_any;
   logic and_prev_all, nand_prev_all;
   logic [1:0] xor_eff;
   logic set_l, rst_l, en_l, inv_l, rall_l, lap_l, start_l;
   logic sfb_core;
   logic [31:0] sw_count;
   logic [31:0] par_val;
   clgb_pkg::clgb_sw_state_t sw_state, next_sw_state;

   function automatic logic sfb_in(input logic v, input logic used);
      sfb_in = used ? v : 1'b0;
   endfunction

   clgb_gate4 u_and (
      .in_val(AND_IN), .in_used(AND_USED), .in_inv(AND_INV),
      .unused_one(1'b1), .all_one(and_all), .any_one());
   clgb_gate4 u_nand (
      .in_val(NAND_IN), .in_used(NAND_USED), .in_inv(NAND_INV),
      .unused_one(1'b1), .all_one(nand_all), .any_one());
   clgb_gate4 u_or (
      .in_val(OR_IN), .in_used(OR_USED), .in_inv(OR_INV),
      .unused_one(1'b0), .all_one(), .any_one(or_any));
   clgb_gate4 u_nor (
      .in_val(NOR_IN), .in_used(NOR_USED), .in_inv(NOR_INV),
      .unused_one(1'b0), .all_one(), .any_one(nor_any));
   clgb_time u_time (
      .timebase(SW_TIMEBASE), .major(PAR_MAJOR), .minor(PAR_MINOR),
      .hundredths(par_val));

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         xor_eff[i] = XOR_USED[i] ? (XOR_IN[i] ^ XOR_INV[i]) : 1'b0;
      end
   end

   assign set_l = sfb_in(SFB_SET, SFB_SET_USED);
   assign rst_l = sfb_in(SFB_RST, SFB_RST_USED);
   assign en_l = sfb_in(SFB_EN, SFB_EN_USED);
   assign inv_l = sfb_in(SFB_INVOUT, SFB_INVOUT_USED);
   assign rall_l = sfb_in(SFB_RALL, SFB_RALL_USED);
   assign lap_l = sfb_in(SFB_LAP, SFB_LAP_USED);
   assign start_l = sfb_in(SFB_START, SFB_START_USED);
   assign scan = (scan_cnt == 16'(SCAN_CYC - 1));
   assign SCAN_TICK = scan;

   // scan cycle pacing
   always_ff @(posedge CLK) begin
      if (RESET || scan) begin
         scan_cnt <= 16'h0;
      end else begin
         scan_cnt <= scan_cnt + 16'h1;
      end
   end

   // 10 ms stopwatch time step
   always_ff @(posedge CLK) begin
      if (RESET || tick_cnt == 32'(TICK10_CYC - 1)) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end
   assign tick10 = (tick_cnt == 32'(TICK10_CYC - 1));

   // basic gates, sampled once per scan
   always_ff @(posedge CLK) begin
      if (RESET) begin
         AND_Q <= 1'b0;
         NAND_Q <= 1'b1;
         OR_Q <= 1'b0;
         NOR_Q <= 1'b1;
         XOR_Q <= 1'b0;
         NOT_Q <= 1'b1;
      end else if (scan) begin
         AND_Q <= and_all;
         NAND_Q <= ~nand_all;
         OR_Q <= or_any;
         NOR_Q <= ~nor_any;
         XOR_Q <= xor_eff[0] ^ xor_eff[1];
         NOT_Q <= ~(NOT_IN ^ NOT_INV);
      end
   end

   // edge gates with previous-scan memory
   always_ff @(posedge CLK) begin
      if (RESET) begin
         and_prev_all <= 1'b1;
         nand_prev_all <= 1'b0;
         AND_EDGE_Q <= 1'b0;
         NAND_EDGE_Q <= 1'b0;
      end else if (scan) begin
         and_prev_all <= and_all;
         nand_prev_all <= nand_all;
         AND_EDGE_Q <= and_all & ~and_prev_all;
         NAND_EDGE_Q <= ~nand_all & nand_prev_all;
      end
   end

   // special function latch with output invert
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sfb_core <= 1'b0;
      end else if (scan) begin
         if (rst_l || rall_l) begin
            sfb_core <= 1'b0;
         end else if (en_l && set_l) begin
            sfb_core <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         SFB_Q <= 1'b0;
      end else if (scan) begin
         if (rst_l || rall_l) begin
            SFB_Q <= 1'b0;
         end else if (en_l) begin
            SFB_Q <= (set_l | sfb_core) ^ inv_l;
         end
      end
   end

   // stopwatch control
   always_comb begin
      next_sw_state = sw_state;
      case (sw_state)
         clgb_pkg::CLGB_SW_IDLE: begin
            if (start_l) begin
               next_sw_state = clgb_pkg::CLGB_SW_RUN;
            end
         end
         clgb_pkg::CLGB_SW_RUN: begin
            if (lap_l) begin
               next_sw_state = clgb_pkg::CLGB_SW_LAP;
            end else if (!start_l) begin
               next_sw_state = clgb_pkg::CLGB_SW_IDLE;
            end
         end
         clgb_pkg::CLGB_SW_LAP: begin
            if (!lap_l) begin
               next_sw_state = start_l ? clgb_pkg::CLGB_SW_RUN
                                       : clgb_pkg::CLGB_SW_IDLE;
            end
         end
         default: begin
            next_sw_state = clgb_pkg::CLGB_SW_IDLE;
         end
      endcase
      if (rst_l || rall_l) begin
         next_sw_state = clgb_pkg::CLGB_SW_IDLE;
      end else if (!en_l) begin
         next_sw_state = sw_state;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sw_state <= clgb_pkg::CLGB_SW_IDLE;
      end else if (scan) begin
         sw_state <= next_sw_state;
      end
   end

   // elapsed time in 10 ms units
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sw_count <= 32'h0;
      end else if (scan && (rst_l || rall_l)) begin
         sw_count <= 32'h0;
      end else if (tick10 && sw_state == clgb_pkg::CLGB_SW_RUN) begin
         sw_count <= sw_count + 32'h1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         SW_ELAPSED <= 32'h0;
         PAR_HUNDREDTHS <= 32'h0;
         SW_RUNNING <= 1'b0;
         SW_PAUSED <= 1'b0;
      end else begin
         if (sw_state != clgb_pkg::CLGB_SW_LAP) begin
            SW_ELAPSED <= sw_count; // frozen during lap
         end
         PAR_HUNDREDTHS <= par_val;
         SW_RUNNING <= (sw_state == clgb_pkg::CLGB_SW_RUN);
         SW_PAUSED <= (sw_state == clgb_pkg::CLGB_SW_LAP);
      end
   end
endmodule

// *** tb/clgb_asserts.sv ***
// checker for the scan-cycle gate outputs
`timescale 1ns/1ps
module clgb_asserts (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic SCAN_TICK,
   input wire logic [3:0] AND_IN,
   input wire logic [3:0] AND_USED,
   input wire logic [3:0] AND_INV,
   input wire logic [3:0] NAND_IN,
   input wire logic [3:0] NAND_USED,
   input wire logic [3:0] NAND_INV,
   input wire logic [3:0] OR_IN,
   input wire logic [3:0] OR_USED,
   input wire logic [3:0] OR_INV,
   input wire logic [3:0] NOR_IN,
   input wire logic [3:0] NOR_USED,
   input wire logic [3:0] NOR_INV,
   input wire logic AND_Q,
   input wire logic AND_EDGE_Q,
   input wire logic NAND_Q,
   input wire logic NAND_EDGE_Q,
   input wire logic OR_Q,
   input wire logic NOR_Q
);
   logic sn;
   logic [3:0] ae, ne, oe, re;
   assign ae = (AND_IN ^ AND_INV) | ~AND_USED;
   assign ne = (NAND_IN ^ NAND_INV) | ~NAND_USED;
   assign oe = (OR_IN ^ OR_INV) & OR_USED;
   assign re = (NOR_IN ^ NOR_INV) & NOR_USED;
   // first scan after reset has no real history
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sn <= 1'b0;
      end else if (SCAN_TICK) begin
         sn <= 1'b1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_gap;
      !SCAN_TICK [*8];
   endsequence
   property p_tick;
      SCAN_TICK |=> s_gap ##32 SCAN_TICK;
   endproperty
   property p_and;
      SCAN_TICK |=> AND_Q == $past(&ae);
   endproperty
   property p_nand;
      SCAN_TICK |=> NAND_Q == $past(~&ne);
   endproperty
   property p_or;
      SCAN_TICK |=> OR_Q == $past(|oe);
   endproperty
   property p_nor;
      SCAN_TICK |=> NOR_Q == $past(~|re);
   endproperty
   property p_aedge;
      SCAN_TICK && sn |=> AND_EDGE_Q == $past(&ae && !AND_Q);
   endproperty
   property p_nedge;
      SCAN_TICK |=> NAND_EDGE_Q == $past(~&ne && !NAND_Q);
   endproperty
   property p_hold;
      !SCAN_TICK |=>
         $stable({AND_Q, NAND_Q, OR_Q, NOR_Q, AND_EDGE_Q, NAND_EDGE_Q});
   endproperty
   a_tick: assert property (p_tick) else $error("bad scan period");
   a_and: assert property (p_and) else $error("and wrong");
   a_nand: assert property (p_nand) else $error("nand wrong");
   a_or: assert property (p_or) else $error("or wrong");
   a_nor: assert property (p_nor) else $error("nor wrong");
   a_aedge: assert property (p_aedge) else $error("and edge");
   a_nedge: assert property (p_nedge) else $error("nand edge");
   a_hold: assert property (p_hold) else $error("output moved");
endmodule
bind clgb_blocks clgb_asserts u_chk (.*);

// *** tb/clgb_peer.sv ***
// process input source feeding the gate inputs
`timescale 1ns/1ps
module clgb_peer (
   input wire logic clk,
   input wire logic tick,
   input wire logic [3:0] val,
   output logic [3:0] gin
);
   initial gin = 4'h0;
   // changes just after a scan sample, stable at the next one
   always @(posedge clk) begin
      if (tick) begin
         gin <= #1 val;
      end
   end
endmodule

// *** tb/clgb_blocks_test.sv ***
// self-checking bench for the gate library
`timescale 1ns/1ps
module clgb_blocks_test;
   logic CLK, RESET, NOT_IN, NOT_INV, SCAN_TICK, a1, pa, su;
   logic [3:0] AND_IN, NAND_IN, OR_IN, NOR_IN, u, iv, val, pv, ae, oe;
   logic [3:0] AND_USED, NAND_USED, OR_USED, NOR_USED;
   logic [3:0] AND_INV, NAND_INV, OR_INV, NOR_INV;
   logic [1:0] XOR_IN, XOR_USED, XOR_INV, SW_TIMEBASE;
   logic SFB_SET, SFB_SET_USED, SFB_RST, SFB_RST_USED, SFB_EN, SFB_EN_USED;
   logic SFB_INVOUT, SFB_INVOUT_USED, SFB_RALL, SFB_RALL_USED, SFB_LAP;
   logic SFB_LAP_USED, SFB_START, SFB_START_USED;
   logic [15:0] PAR_MAJOR, PAR_MINOR;
   logic AND_Q, AND_EDGE_Q, NAND_Q, NAND_EDGE_Q, OR_Q, NOR_Q, XOR_Q;
   logic NOT_Q, SFB_Q, SW_RUNNING, SW_PAUSED;
   logic [31:0] SW_ELAPSED, PAR_HUNDREDTHS;
   logic [6:0] rw;
   logic [6:0] rows [6] = '{7'h69, 7'h58, 7'h60, 7'h4d, 7'h6a, 7'h28};
   logic [31:0] hx [4] = '{32'h000000cd, 32'h000030d4, 32'h000b71b0,
      32'h00000005};
   int error_cnt, samples_checked;
   assign {AND_USED, NAND_USED, OR_USED, NOR_USED} = {4{u}};
   assign {AND_INV, NAND_INV, OR_INV, NOR_INV} = {4{iv}};
   assign {NAND_IN, OR_IN, NOR_IN} = {3{AND_IN}};
   assign {XOR_IN, XOR_USED, XOR_INV} = {AND_IN[1:0], u[1:0], iv[1:0]};
   assign {NOT_IN, NOT_INV} = {AND_IN[0], iv[0]};
   assign {SFB_RST_USED, SFB_EN_USED, SFB_INVOUT_USED} = {3{su}};
   assign {SFB_RALL_USED, SFB_LAP_USED, SFB_START_USED} = {3{su}};
   assign {SFB_SET_USED, SFB_SET, SFB_RST, SFB_EN, SFB_INVOUT, SFB_RALL} =
      rw[6:1];
   clgb_blocks dut (.*);
   clgb_peer peer (.clk(CLK), .tick(SCAN_TICK), .val(val), .gin(AND_IN));
   task end_sim;
      if (error_cnt == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %0t: saw %h want %h", $time, s, e);
      end
   endtask
   // waits for the next scan sample edge
   task tk;
      int n;
      n = 0;
      while (SCAN_TICK !== 1'b1 && n < 60) begin
         @(posedge CLK);
         #1;
         n++;
      end
      if (n >= 60) begin
         error_cnt++;
         end_sim();
      end
      @(posedge CLK);
      #1;
   endtask
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      error_cnt = 0;
      samples_checked = 0;
      RESET = 1'b1;
      {u, iv, val, pv, su, rw} = {4'hf, 4'h0, 4'h0, 4'h0, 1'b1, 7'h00};
      {SFB_LAP, SFB_START, SW_TIMEBASE} = 4'h0;
      PAR_MAJOR = 16'h0002;
      PAR_MINOR = 16'h0005;
      repeat (8) @(posedge CLK);
      #1;
      chk({AND_Q, NAND_Q, OR_Q, NOR_Q, XOR_Q, NOT_Q, SFB_Q}, 7'h2a);
      RESET = 1'b0;
      tk();
      for (int c = 0; c < 3; c++) begin
         for (int v = 0; v < 16; v++) begin
            u = (c == 2) ? 4'h3 : 4'hf;
            iv = (c == 1) ? 4'h5 : 4'h0;
            val = v[3:0];
            tk();
            tk();
            ae = (val ^ iv) | ~u;
            oe = (val ^ iv) & u;
            a1 = &ae;
            pa = &((pv ^ iv) | ~u);
            chk(AND_Q, a1);
            chk(NAND_Q, !a1);
            chk(OR_Q, |oe);
            chk(NOR_Q, !(|oe));
            chk(XOR_Q, ^oe[1:0]);
            chk(NOT_Q, !(val[0] ^ iv[0]));
            chk(AND_EDGE_Q, a1 && !pa);
            chk(NAND_EDGE_Q, !a1 && pa);
            pv = val;
         end
      end
      foreach (rows[i]) begin
         rw = rows[i];
         tk();
         chk(SFB_Q, rw[0]);
      end
      rw = 7'h08;
      SFB_START = 1'b1;
      tk();
      tk();
      chk(SW_RUNNING, 1'b1);
      SFB_LAP = 1'b1;
      tk();
      tk();
      chk(SW_PAUSED, 1'b1);
      rw = 7'h0a;
      tk();
      tk();
      chk(SW_PAUSED, 1'b0);
      chk(SW_RUNNING, 1'b0);
      chk(SW_ELAPSED, 32'h0);
      for (int t = 0; t < 4; t++) begin
         SW_TIMEBASE = t[1:0];
         @(posedge CLK);
         @(posedge CLK);
         #1;
         chk(PAR_HUNDREDTHS, hx[t]);
      end
      end_sim();
   end
endmodule
